//--- design/rre_exec.sv
// executor for return and rotate-through-carry instructions
// Summary of operation
// - return from interrupt pops the stack into the pc, two cycles.
// - return from interrupt also sets interrupt enable, control bit 7.
// - return from subroutine pops stack into pc, two cycles, flags unchanged.
// - return with literal loads literal into w, pops into pc, two cycles.
// - rotate left: old carry into bit 0, old bit 7 into carry.
// - destination 0 writes w, 1 writes file register; one cycle.
`timescale 1ns/1ps
`default_nettype none
module rre_exec
  import rre_pkg::*;
(
  // clock and reset
  input  wire logic           mclk_in,
  input  wire logic           srst_in,
  // instruction from decode, taken when ready_out is high
  input  wire logic           instr_valid_in,
  input  wire rre_instr_type  instr_in,
  input  wire logic [7:0]     fdata_in,
  // call path from the rest of the core
  input  wire logic           call_in,
  input  wire logic [12:0]    call_target_in,
  input  wire logic [12:0]    return_addr_in,
  // results
  output logic                ready_out,
  output logic                done_out,
  output logic [12:0]         pc_out,
  output logic [7:0]          wreg_out,
  output logic                carry_out,
  output logic [7:0]          interrupt_control_reg_out,
  output rre_fwrite_type      fwrite_out,
  output logic [3:0]          stack_ptr_out
);

  typedef enum logic [0:0] {ST_IDLE, ST_POP} rre_state_type;

  rre_state_type state;
  logic [12:0]   stack_top_entry;
  logic [3:0]    sptr;
  logic          take;
  logic          is_ret;
  logic          pop;
  logic [8:0]    rot;

  function automatic logic is_return(input rre_op_type op);
    return (op == RRE_OP_RETFI) || (op == RRE_OP_RETSUB) || (op == RRE_OP_RETLIT);
  endfunction : is_return

  assign take   = instr_valid_in && (state == ST_IDLE);
  assign is_ret = take && is_return(instr_in.op);
  assign pop    = is_ret;
  assign rot    = {fdata_in, carry_out};

  // a call in the same cycle as a return is dropped; the return owns the stack
  rre_stack #(
    .DEPTH (STACK_DEPTH),
    .AW    (PTR_WIDTH),
    .W     (PC_WIDTH)
  ) u_stack (
    .mclk_in      (mclk_in),
    .srst_in      (srst_in),
    .push_in      (call_in && !pop),
    .push_data_in (return_addr_in),
    .pop_in       (pop),
    .top_out      (stack_top_entry),
    .ptr_out      (sptr)
  );

  // returns spend a second, flushing cycle
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      state <= ST_IDLE;
    else if (is_ret)
      state <= ST_POP;
    else
      state <= ST_IDLE;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      ready_out <= 1'b1;
    else
      ready_out <= !is_ret;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      done_out <= 1'b0;
    else
      done_out <= (state == ST_POP) || (take && instr_in.op == RRE_OP_ROTL);
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      pc_out <= PC_RESET;
    else if (is_ret)
      pc_out <= stack_top_entry;
    // a call colliding with a return loses; the popped entry wins
    else if (call_in)
      pc_out <= call_target_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      interrupt_control_reg_out <= ICR_RESET;
    else if (take && instr_in.op == RRE_OP_RETFI)
      interrupt_control_reg_out[INT_ENABLE_BIT] <= 1'b1;
  end

  // only the rotate touches carry; returns leave flags alone
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      carry_out <= 1'b0;
    else if (take && instr_in.op == RRE_OP_ROTL)
      carry_out <= rot[8];
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      wreg_out <= W_RESET;
    else if (take && instr_in.op == RRE_OP_RETLIT)
      wreg_out <= instr_in.literal;
    else if (take && instr_in.op == RRE_OP_ROTL && instr_in.dest == DEST_WREG)
      wreg_out <= rot[7:0];
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      fwrite_out <= '0;
    else
    begin
      fwrite_out.en   <= take && instr_in.op == RRE_OP_ROTL && instr_in.dest == DEST_FILE;
      fwrite_out.addr <= instr_in.faddr;
      fwrite_out.data <= rot[7:0];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      stack_ptr_out <= '0;
    else
      stack_ptr_out <= sptr;
  end

  // checks
  chk_ret_pc_load: assert property (@(posedge mclk_in) disable iff (srst_in)
    is_ret |=> pc_out == $past(stack_top_entry))
    else $error("return did not load pc from stack top");

  chk_ret_two_cycle: assert property (@(posedge mclk_in) disable iff (srst_in)
    is_ret |=> !ready_out ##1 (ready_out && done_out))
    else $error("return did not take two cycles");

  chk_int_enable_set: assert property (@(posedge mclk_in) disable iff (srst_in)
    (take && instr_in.op == RRE_OP_RETFI) |=> interrupt_control_reg_out[INT_ENABLE_BIT])
    else $error("interrupt enable not set");

  chk_lit_to_w: assert property (@(posedge mclk_in) disable iff (srst_in)
    (take && instr_in.op == RRE_OP_RETLIT) |=> wreg_out == $past(instr_in.literal))
    else $error("literal not in w");

  chk_rot_carry: assert property (@(posedge mclk_in) disable iff (srst_in)
    (take && instr_in.op == RRE_OP_ROTL)
      |=> carry_out == $past(fdata_in[7]))
    else $error("carry not old bit 7");

  chk_rot_file: assert property (@(posedge mclk_in) disable iff (srst_in)
    (take && instr_in.op == RRE_OP_ROTL && instr_in.dest)
      |=> fwrite_out.en && fwrite_out.data == {$past(fdata_in[6:0]), $past(carry_out)} && done_out)
    else $error("rotate file writeback wrong");

  chk_ret_flags: assert property (@(posedge mclk_in) disable iff (srst_in)
    is_ret |=> $stable(carry_out))
    else $error("return changed carry");

  chk_pop_ptr: assert property (@(posedge mclk_in) disable iff (srst_in)
    is_ret |=> sptr == $past(sptr) - 4'h1)
    else $error("pop did not move pointer back");

  chk_rot_one_cycle: assert property (@(posedge mclk_in) disable iff (srst_in)
    (take && instr_in.op == RRE_OP_ROTL) |=> done_out && ready_out)
    else $error("rotate did not finish in one cycle");

  chk_rot_wreg: assert property (@(posedge mclk_in) disable iff (srst_in)
    (take && instr_in.op == RRE_OP_ROTL && instr_in.dest == DEST_WREG)
      |=> !fwrite_out.en && wreg_out == {$past(fdata_in[6:0]), $past(carry_out)})
    else $error("rotate to w wrong");

  chk_rot_icr_kept: assert property (@(posedge mclk_in) disable iff (srst_in)
    (take && instr_in.op == RRE_OP_ROTL) |=> $stable(interrupt_control_reg_out))
    else $error("rotate touched interrupt control");

  chk_ret_keep_w: assert property (@(posedge mclk_in) disable iff (srst_in)
    (is_ret && instr_in.op != RRE_OP_RETLIT)
      |=> $stable(wreg_out) && !fwrite_out.en)
    else $error("plain return touched w or file");

  chk_ret_icr_kept: assert property (@(posedge mclk_in) disable iff (srst_in)
    (is_ret && instr_in.op != RRE_OP_RETFI) |=> $stable(interrupt_control_reg_out))
    else $error("return changed interrupt control");

  chk_flush_ignore: assert property (@(posedge mclk_in) disable iff (srst_in)
    (!ready_out && instr_valid_in && !call_in) |=> $stable(pc_out) && $stable(sptr))
    else $error("instruction acted during return flush");

  chk_call_push: assert property (@(posedge mclk_in) disable iff (srst_in)
    (call_in && !is_ret) |=> sptr == $past(sptr) + 4'h1)
    else $error("call did not push one entry");

endmodule : rre_exec
`default_nettype wire

//--- design/rre_pkg.sv
// package for the return and rotate instruction executor
package rre_pkg;

  localparam int PC_WIDTH        = 13;
  localparam int STACK_DEPTH     = 16;
  localparam int PTR_WIDTH       = 4;
  localparam int DATA_WIDTH      = 8;
  localparam int FADDR_WIDTH     = 7;
  localparam int INT_ENABLE_BIT  = 7;
  localparam int RETURN_CYCLES   = 2;
  localparam int ROTATE_CYCLES   = 1;
  localparam logic [7:0] ICR_RESET = 8'h00;
  localparam logic [7:0] W_RESET   = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic DEST_WREG     = 1'b0;
  localparam logic DEST_FILE     = 1'b1;

  typedef enum logic [2:0] {
    RRE_OP_NONE,
    RRE_OP_RETFI,
    RRE_OP_RETSUB,
    RRE_OP_RETLIT,
    RRE_OP_ROTL
  } rre_op_type;

  // one decoded instruction from the decode path
  typedef struct packed {
    rre_op_type       op;
    logic [7:0]       literal;
    logic [6:0]       faddr;
    logic             dest;
  } rre_instr_type;

  // writeback to the file register array
  typedef struct packed {
    logic             en;
    logic [6:0]       addr;
    logic [7:0]       data;
  } rre_fwrite_type;

endpackage : rre_pkg

//--- design/rre_stack.sv
// hardware return stack, flip-flop storage, circular
`timescale 1ns/1ps
`default_nettype none
module rre_stack
  import rre_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int AW    = PTR_WIDTH,
  parameter int W     = PC_WIDTH
)(
  // clock and reset
  input  wire logic          mclk_in,
  input  wire logic          srst_in,
  // push and pop
  input  wire logic          push_in,
  input  wire logic [W-1:0]  push_data_in,
  input  wire logic          pop_in,
  // state
  output logic [W-1:0]       top_out,
  output logic [AW-1:0]      ptr_out
);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] ptr;

  // ptr names the next free slot; top is the slot below it
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      ptr <= '0;
    else if (push_in && !pop_in)
      ptr <= ptr + AW'(1);
    else if (pop_in && !push_in)
      ptr <= ptr - AW'(1);
  end

  always_ff @(posedge mclk_in)
  begin
    if (push_in)
      mem[ptr] <= push_data_in;
  end

  assign top_out = mem[ptr - AW'(1)];
  assign ptr_out = ptr;

endmodule : rre_stack
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the return and rotate executor
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rre_pkg::*;
;
  logic           mclk_in = 1'b0;
  logic           srst_in = 1'b1;
  logic           instr_valid_in = 1'b0;
  rre_instr_type  instr_in = '0;
  logic [7:0]     fdata_in = 8'h00;
  logic           call_in = 1'b0;
  logic [12:0]    call_target_in = 13'h0000;
  logic [12:0]    return_addr_in = 13'h0000;
  logic           ready_out;
  logic           done_out;
  logic [12:0]    pc_out;
  logic [7:0]     wreg_out;
  logic           carry_out;
  logic [7:0]     interrupt_control_reg_out;
  rre_fwrite_type fwrite_out;
  logic [3:0]     stack_ptr_out;
  int             fail_count = 0;
  int             checks = 0;

  always #20 mclk_in = ~mclk_in;

  rre_exec rre_exec_i (.mclk_in(mclk_in), .srst_in(srst_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .fdata_in(fdata_in), .call_in(call_in),
    .call_target_in(call_target_in), .return_addr_in(return_addr_in),
    .ready_out(ready_out), .done_out(done_out), .pc_out(pc_out), .wreg_out(wreg_out),
    .carry_out(carry_out), .interrupt_control_reg_out(interrupt_control_reg_out),
    .fwrite_out(fwrite_out), .stack_ptr_out(stack_ptr_out));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : check

  // on a return, a hold of two lets the one extra edge fall in the refused window
  task automatic send(input rre_op_type op, input logic [7:0] lit, input logic dst,
                      input logic [7:0] fd, input logic [6:0] fa, input int hold);
    @(posedge mclk_in);
    instr_valid_in <= 1'b1;
    instr_in       <= '{op: op, literal: lit, faddr: fa, dest: dst};
    fdata_in       <= fd;
    repeat (hold) @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    #1;
  endtask : send

  task automatic do_call(input logic [12:0] tgt, input logic [12:0] ret);
    @(posedge mclk_in);
    call_in        <= 1'b1;
    call_target_in <= tgt;
    return_addr_in <= ret;
    @(posedge mclk_in);
    call_in        <= 1'b0;
    @(posedge mclk_in);
    #1;
  endtask : do_call

  task automatic t_reset();
    check(pc_out, 16'h0000, "pc reset");
    check({wreg_out, interrupt_control_reg_out}, 16'h0000, "w icr reset");
    check({carry_out, ready_out, done_out, fwrite_out.en}, 16'h0004, "flags reset");
    check(stack_ptr_out, 16'h0000, "ptr reset");
  endtask : t_reset

  task automatic t_rotate();
    send(RRE_OP_ROTL, 8'h00, DEST_FILE, 8'hE6, 7'h7F, 1);
    check({fwrite_out.en, fwrite_out.addr}, 16'h00FF, "file write addr");
    check(fwrite_out.data, 16'h00CC, "rotated data");
    check({carry_out, done_out}, 16'h0003, "carry and done");
    check(wreg_out, 16'h0000, "w kept on file dest");
    @(posedge mclk_in);
    #1;
    check({fwrite_out.en, done_out}, 16'h0000, "write pulse one cycle");
    send(RRE_OP_ROTL, 8'h00, DEST_WREG, 8'h40, 7'h00, 1);
    check({wreg_out, 7'h00, carry_out}, 16'h8100, "carry into bit 0");
    check(fwrite_out.en, 16'h0000, "no file write on w dest");
    send(RRE_OP_ROTL, 8'h00, DEST_WREG, 8'h81, 7'h00, 1);
    check({wreg_out, 7'h00, carry_out}, 16'h0201, "bit 7 into carry");
  endtask : t_rotate

  task automatic t_ret_literal();
    do_call(13'h0100, 13'h0123);
    do_call(13'h0200, 13'h1456);
    check(stack_ptr_out, 16'h0002, "ptr after calls");
    send(RRE_OP_RETLIT, 8'hFF, 1'b0, 8'h00, 7'h00, 1);
    check(pc_out, 16'h1456, "literal return pc");
    check({wreg_out, ready_out, done_out}, 16'h03FC, "w loaded, busy");
    @(posedge mclk_in);
    #1;
    check({ready_out, done_out, carry_out}, 16'h0007, "done second cycle");
    check(stack_ptr_out, 16'h0001, "ptr back one");
  endtask : t_ret_literal

  // second valid edge falls while busy and must not pop again
  task automatic t_ret_sub();
    send(RRE_OP_RETSUB, 8'h00, 1'b0, 8'h00, 7'h00, 2);
    check({done_out, carry_out}, 16'h0003, "done, carry kept");
    check(pc_out, 16'h0123, "subroutine return pc");
    check(stack_ptr_out, 16'h0000, "single pop");
    check({wreg_out, interrupt_control_reg_out}, 16'hFF00, "w and icr kept");
  endtask : t_ret_sub

  task automatic t_ret_int();
    do_call(13'h0300, 13'h00AB);
    send(RRE_OP_RETFI, 8'h00, 1'b0, 8'h00, 7'h00, 1);
    check(pc_out, 16'h00AB, "interrupt return pc");
    check(interrupt_control_reg_out, 16'h0080, "enable set");
    check({ready_out, done_out}, 16'h0000, "busy first cycle");
    @(posedge mclk_in);
    #1;
    check({ready_out, done_out}, 16'h0003, "done second cycle");
    check(stack_ptr_out, 16'h0000, "ptr back one");
  endtask : t_ret_int

  // a call landing with a return is dropped; only the pop happens
  task automatic t_call_ret();
    do_call(13'h0400, 13'h0055);
    @(posedge mclk_in);
    instr_valid_in <= 1'b1;
    instr_in       <= '{op: RRE_OP_RETSUB, literal: 8'h00, faddr: 7'h00, dest: 1'b0};
    call_in        <= 1'b1;
    call_target_in <= 13'h0999;
    return_addr_in <= 13'h0777;
    @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    call_in        <= 1'b0;
    #1;
    check(pc_out, 16'h0055, "return beats call");
    @(posedge mclk_in);
    #1;
    check(stack_ptr_out, 16'h0000, "no push with pop");
  endtask : t_call_ret

  // rotates back to back, no idle cycle between
  task automatic t_rot_pair();
    @(posedge mclk_in);
    instr_valid_in <= 1'b1;
    instr_in       <= '{op: RRE_OP_ROTL, literal: 8'h00, faddr: 7'h00, dest: DEST_WREG};
    fdata_in       <= 8'h01;
    @(posedge mclk_in);
    instr_in       <= '{op: RRE_OP_ROTL, literal: 8'h00, faddr: 7'h11, dest: DEST_FILE};
    fdata_in       <= 8'h80;
    @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    #1;
    check(wreg_out, 16'h0003, "first rotate to w");
    check({fwrite_out.en, fwrite_out.addr}, 16'h0091, "second rotate to file");
    check(fwrite_out.data, 16'h0000, "carry from first rotate");
    check({carry_out, done_out}, 16'h0003, "carry from bit 7");
  endtask : t_rot_pair

  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // whole sequence is well under a hundred cycles
  initial
  begin
    #20000;
    fail_count++;
    final_report();
  end

  initial
  begin
    repeat (8) @(posedge mclk_in);
    srst_in <= 1'b0;
    #1;
    t_reset();
    t_rotate();
    t_ret_literal();
    t_ret_sub();
    t_ret_int();
    t_call_ret();
    t_rot_pair();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
